//--- cl_pkg.sv
// Constants, encodings and carrier types of the custom logic unit.
package cl_pkg;
   localparam int NUM_TABLES = 4;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int FILTER_LEN = 4;
   localparam logic [4:0] OFF_MAIN = 5'h00;
   localparam logic [4:0] OFF_SEQ_A = 5'h01;
   localparam logic [4:0] OFF_SEQ_B = 5'h02;
   localparam logic [4:0] OFF_SENSE = 5'h05;
   localparam logic [4:0] OFF_FLAGS = 5'h07;
   localparam logic [4:0] OFF_TABLE_FIRST = 5'h08;
   localparam logic [4:0] OFF_TABLE_LAST = 5'h17;
   localparam logic [2:0] TABLE_INDEX_BASE = 3'h2;
   localparam logic [1:0] SUB_CTRL_FIRST = 2'h0;
   localparam logic [1:0] SUB_INPUT_LOW = 2'h1;
   localparam logic [1:0] SUB_INPUT_HIGH = 2'h2;
   localparam logic [1:0] SUB_TRUTH = 2'h3;
   localparam int MAIN_ENABLE_BIT = 0;
   localparam int MAIN_KEEP_BIT = 6;
   localparam logic [7:0] MAIN_READ_MASK = 8'h41;
   localparam int TC_ENABLE_BIT = 0;
   localparam int TC_CLK_LSB = 1;
   localparam int TC_COND_LSB = 4;
   localparam int TC_DRIVE_BIT = 6;
   localparam int TC_EDGE_BIT = 7;
   localparam int SEL_LOW_LSB = 0;
   localparam int SEL_HIGH_LSB = 4;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   typedef enum logic [3:0] {
      SEQ_OFF = 4'h0, SEQ_DFF = 4'h1, SEQ_JK = 4'h2,
      SEQ_DLATCH = 4'h3, SEQ_RS = 4'h4
   } seq_mode_type;
   typedef enum logic [1:0] {
      SENSE_OFF = 2'h0, SENSE_RISE = 2'h1, SENSE_FALL = 2'h2,
      SENSE_BOTH = 2'h3
   } sense_type;
   typedef enum logic [1:0] {
      COND_NONE = 2'h0, COND_SYNC = 2'h1, COND_FILTER = 2'h2
   } cond_type;
   typedef enum logic [2:0] {
      CLK_PERIPH = 3'h0, CLK_IN2 = 3'h1, CLK_FAST = 3'h4,
      CLK_SLOW = 3'h5, CLK_DIV_SLOW = 3'h6
   } clk_src_type;
   typedef enum logic [3:0] {
      IN_MASK = 4'h0, IN_FEEDBACK = 4'h1, IN_LINK = 4'h2,
      IN_EVENT_A = 4'h3, IN_EVENT_B = 4'h4, IN_PIN = 4'h5,
      IN_COMP = 4'h6, IN_SERIAL = 4'h8, IN_SPI = 4'h9,
      IN_TIMER_A = 4'ha, IN_TIMER_B = 4'hc
   } in_src_type;
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;
   typedef struct packed {
      logic [3:0] event_a;
      logic [3:0] event_b;
      logic [11:0] pin;
      logic comp;
      logic [2:0] serial_tx;
      logic spi_mosi;
      logic spi_sck;
      logic [2:0] timer_a;
      logic [2:0] timer_b;
      logic fast_osc;
      logic slow_osc;
      logic div_slow_osc;
   } src_pins_type;
endpackage : cl_pkg

//--- table_cond.sv
// Output conditioning of one table: synchronizer, filter, edge detector.
`timescale 1ns/1ns
module table_cond #(
   parameter int FILT_LEN = cl_pkg::FILTER_LEN
) (
   input wire logic clk_i,       // Core clock
   input wire logic rst_n_i,     // Synchronised reset, active low
   input wire logic raw_i,       // Registered truth output
   input wire logic tick_i,      // Table clock tick
   input wire logic [1:0] mode_i, // Conditioning select
   input wire logic edge_en_i,   // Edge detector enable
   output logic cond_o           // Conditioned output
);
   logic [1:0] stage_r;
   logic [FILT_LEN-1:0] filt_r;
   logic level_r;
   logic level_nxt;
   logic edge_prev_r;
   logic sel;
   // Sample chains advance only on the table clock tick
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage_r <= 2'h0;
         filt_r <= '0;
      end else if (tick_i) begin
         stage_r <= {stage_r[0], raw_i};
         filt_r <= {filt_r[FILT_LEN-2:0], raw_i};
      end
   end
   // Filter changes level only after a full run of equal samples
   always_comb begin
      level_nxt = level_r;
      if (&filt_r) level_nxt = 1'b1;
      if (~|filt_r) level_nxt = 1'b0;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) level_r <= 1'b0;
      else level_r <= level_nxt;
   end
   // Reserved select falls back to the raw path
   always_comb begin
      unique case (cl_pkg::cond_type'(mode_i))
         cl_pkg::COND_SYNC: sel = stage_r[1];
         cl_pkg::COND_FILTER: sel = level_r;
         default: sel = raw_i;
      endcase
   end
   // Edge memory follows the table clock so a pulse spans one tick
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) edge_prev_r <= 1'b0;
      else if (tick_i) edge_prev_r <= sel;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) cond_o <= 1'b0;
      else cond_o <= edge_en_i ? (sel & ~edge_prev_r) : sel;
   end
endmodule : table_cond

//--- seq_unit.sv
// Shared flip-flop or latch sequencer of one table pair.
`timescale 1ns/1ns
module seq_unit (
   input wire logic clk_i,        // Core clock
   input wire logic rst_n_i,      // Synchronised reset, active low
   input wire logic [3:0] mode_i, // Sequencer select
   input wire logic tick_i,       // Even table clock tick
   input wire logic even_i,       // Even table output
   input wire logic odd_i,        // Odd table output
   output logic q_o               // Sequencer state
);
   // Latches follow every core cycle, flip-flops only the even tick
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_o <= 1'b0;
      end else begin
         case (cl_pkg::seq_mode_type'(mode_i))
            cl_pkg::SEQ_DFF: begin
               if (tick_i && odd_i) q_o <= even_i;
            end
            cl_pkg::SEQ_JK: begin
               if (tick_i) begin
                  if (even_i && odd_i) q_o <= ~q_o;
                  else if (even_i) q_o <= 1'b1;
                  else if (odd_i) q_o <= 1'b0;
               end
            end
            cl_pkg::SEQ_DLATCH: begin
               if (odd_i) q_o <= even_i;
            end
            cl_pkg::SEQ_RS: begin
               if (even_i) q_o <= 1'b1;
               else if (odd_i) q_o <= 1'b0;
            end
            default: q_o <= 1'b0; // Off and reserved codes
         endcase
      end
   end
endmodule : seq_unit

//--- custom_logic_unit.sv
// Top of the custom logic unit: registers, tables, flags and pins.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
module custom_logic_unit (
   input wire logic core_clk_i,              // Core clock, 20 MHz
   input wire logic arst_n_i,                // Async reset, active low
   input cl_pkg::reg_req_type bus_i,         // Register request
   output logic [7:0] rd_data_o,             // Read data, next cycle
   input cl_pkg::src_pins_type src_i,        // Asynchronous sources
   input wire logic standby_i,               // Standby sleep active
   output logic [3:0] table_output_o,        // Table outputs and events
   output logic [3:0] pin_drive_o,           // Pin output enables
   output logic clock_keep_req_o,            // Keep peripheral clock
   output logic irq_o                        // Interrupt request
);
   localparam int NT = cl_pkg::NUM_TABLES;

   logic [1:0] rst_sync_r;
   logic rst_n;
   cl_pkg::src_pins_type src_meta_r;
   cl_pkg::src_pins_type src_r;
   logic [7:0] main_r;
   logic [3:0] seq_a_r;
   logic [3:0] seq_b_r;
   logic [7:0] sense_r;
   logic [3:0] flags_r;
   logic [7:0] ctrl_first_r [NT];
   logic [7:0] ctrl_in_low_r [NT];
   logic [3:0] ctrl_in_high_r [NT];
   logic [7:0] truth_r [NT];
   logic [7:0] rd_data_r;
   logic [NT-1:0] raw_r;
   logic [NT-1:0] cond_w;
   logic [NT-1:0] pre_w;
   logic [NT-1:0] out_r;
   logic [NT-1:0] out_prev_r;
   logic [NT-1:0] tick_w;
   logic [NT-1:0] forced_w;
   logic [NT-1:0] hit_w;
   logic [NT-1:0] needs_clk_w;
   logic [NT-1:0] in2_prev_r;
   logic [2:0] osc_prev_r;
   logic [1:0] seq_q_w;
   logic [1:0] seq_on_w;
   logic unit_on;
   logic keep_clk;
   logic table_hit;
   logic [1:0] table_sub;
   logic [1:0] table_idx;
   logic wr_open;
   logic [3:0] flag_clear;

   // Reset release passes two flops so every domain sees a clean edge
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) rst_sync_r <= 2'h0;
      else rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // Every outside source is brought in through two flops
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         src_meta_r <= '0;
         src_r <= '0;
      end else begin
         src_meta_r <= src_i;
         src_r <= src_meta_r;
      end
   end

   assign unit_on = main_r[cl_pkg::MAIN_ENABLE_BIT];
   assign keep_clk = main_r[cl_pkg::MAIN_KEEP_BIT];

   // Decode of the per-table register block
   assign table_hit = (bus_i.addr >= cl_pkg::OFF_TABLE_FIRST) &&
                      (bus_i.addr <= cl_pkg::OFF_TABLE_LAST);
   assign table_sub = bus_i.addr[1:0];
   assign table_idx = 2'(bus_i.addr[4:2] - cl_pkg::TABLE_INDEX_BASE);
   // Protected registers only open while the unit is off; changing
   // clocks or sequencers on a running unit gives undefined outputs
   assign wr_open = bus_i.wr && !unit_on;
   assign flag_clear = (bus_i.wr && bus_i.addr == cl_pkg::OFF_FLAGS) ?
                       bus_i.wdata[3:0] : 4'h0;

   // Main control and sense control are always writable
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         main_r <= cl_pkg::RESET_BYTE;
         sense_r <= cl_pkg::RESET_BYTE;
      end else if (bus_i.wr) begin
         if (bus_i.addr == cl_pkg::OFF_MAIN)
            main_r <= bus_i.wdata & cl_pkg::MAIN_READ_MASK;
         if (bus_i.addr == cl_pkg::OFF_SENSE)
            sense_r <= bus_i.wdata;
      end
   end

   // Sequencer selectors of both pairs
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         seq_a_r <= 4'h0;
         seq_b_r <= 4'h0;
      end else if (wr_open) begin
         if (bus_i.addr == cl_pkg::OFF_SEQ_A)
            seq_a_r <= bus_i.wdata[3:0];
         if (bus_i.addr == cl_pkg::OFF_SEQ_B)
            seq_b_r <= bus_i.wdata[3:0];
      end
   end

   // Per-table control, input selects and truth bytes
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NT; i++) begin
            ctrl_first_r[i] <= cl_pkg::RESET_BYTE;
            ctrl_in_low_r[i] <= cl_pkg::RESET_BYTE;
            ctrl_in_high_r[i] <= 4'h0;
            truth_r[i] <= cl_pkg::RESET_BYTE;
         end
      end else if (wr_open && table_hit) begin
         unique case (table_sub)
            cl_pkg::SUB_CTRL_FIRST: ctrl_first_r[table_idx] <= bus_i.wdata;
            cl_pkg::SUB_INPUT_LOW: ctrl_in_low_r[table_idx] <= bus_i.wdata;
            cl_pkg::SUB_INPUT_HIGH:
               ctrl_in_high_r[table_idx] <= bus_i.wdata[3:0];
            cl_pkg::SUB_TRUTH: truth_r[table_idx] <= bus_i.wdata;
         endcase
      end
   end

   // Read data live one cycle after the strobe and read zero otherwise
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= 8'h00;
      end else if (!bus_i.rd) begin
         rd_data_r <= 8'h00;
      end else if (table_hit) begin
         unique case (table_sub)
            cl_pkg::SUB_CTRL_FIRST: rd_data_r <= ctrl_first_r[table_idx];
            cl_pkg::SUB_INPUT_LOW: rd_data_r <= ctrl_in_low_r[table_idx];
            cl_pkg::SUB_INPUT_HIGH:
               rd_data_r <= {4'h0, ctrl_in_high_r[table_idx]};
            cl_pkg::SUB_TRUTH: rd_data_r <= truth_r[table_idx];
         endcase
      end else begin
         case (bus_i.addr)
            cl_pkg::OFF_MAIN: rd_data_r <= main_r;
            cl_pkg::OFF_SEQ_A: rd_data_r <= {4'h0, seq_a_r};
            cl_pkg::OFF_SEQ_B: rd_data_r <= {4'h0, seq_b_r};
            cl_pkg::OFF_SENSE: rd_data_r <= sense_r;
            cl_pkg::OFF_FLAGS: rd_data_r <= {4'h0, flags_r};
            default: rd_data_r <= 8'h00; // Unmapped and reserved
         endcase
      end
   end
   assign rd_data_o = rd_data_r;

   // Picks one table input; serial and timer lines follow input index
   function automatic logic pick_input(
      input logic [3:0] sel,
      input int x,
      input int n,
      input logic fb,
      input logic link,
      input cl_pkg::src_pins_type s
   );
      logic v;
      v = 1'b0;
      case (cl_pkg::in_src_type'(sel))
         cl_pkg::IN_FEEDBACK: v = fb;
         cl_pkg::IN_LINK: v = link;
         cl_pkg::IN_EVENT_A: v = s.event_a[n];
         cl_pkg::IN_EVENT_B: v = s.event_b[n];
         cl_pkg::IN_PIN: v = s.pin[n*3+x];
         cl_pkg::IN_COMP: v = s.comp;
         cl_pkg::IN_SERIAL: v = s.serial_tx[x];
         cl_pkg::IN_SPI: v = (x == 2) ? s.spi_sck : s.spi_mosi;
         cl_pkg::IN_TIMER_A: v = s.timer_a[x];
         cl_pkg::IN_TIMER_B: v = s.timer_b[x];
         default: v = 1'b0; // Masked and reserved
      endcase
      return v;
   endfunction : pick_input

   // Oscillator inputs turn into one-cycle ticks on their rising edge
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) osc_prev_r <= 3'h0;
      else osc_prev_r <= {src_r.div_slow_osc, src_r.slow_osc,
                          src_r.fast_osc};
   end

   // Sequencers of both pairs
   for (genvar p = 0; p < 2; p++) begin : g_pair
      logic [3:0] mode;
      assign mode = (p == 0) ? seq_a_r : seq_b_r;
      assign seq_on_w[p] = (mode != 4'h0);
      seq_unit u_seq (
         .clk_i(core_clk_i),
         .rst_n_i(rst_n),
         .mode_i(mode),
         .tick_i(tick_w[2*p]),
         .even_i(cond_w[2*p]),
         .odd_i(cond_w[2*p+1]),
         .q_o(seq_q_w[p])
      );
   end

   // One lookup table with its inputs, clock, conditioning and flag
   for (genvar n = 0; n < NT; n++) begin : g_table
      logic [7:0] ca;
      logic [2:0] idx;
      logic fb;
      logic link;
      logic active;
      logic rise;
      logic fall;
      logic [2:0] src;
      assign ca = ctrl_first_r[n];
      assign src = ca[cl_pkg::TC_CLK_LSB +: 3];
      assign active = unit_on && ca[cl_pkg::TC_ENABLE_BIT];
      // Feedback comes from the registered output to break loops
      assign fb = seq_on_w[n/2] ? seq_q_w[n/2] : out_r[n];
      assign link = out_r[(n+1)%NT];
      assign idx[0] = pick_input(ctrl_in_low_r[n][cl_pkg::SEL_LOW_LSB +: 4],
                                 0, n, fb, link, src_r);
      assign idx[1] = pick_input(ctrl_in_low_r[n][cl_pkg::SEL_HIGH_LSB +: 4],
                                 1, n, fb, link, src_r);
      assign idx[2] = pick_input(ctrl_in_high_r[n], 2, n, fb, link, src_r);

      // Truth byte lookup, registered to cut combinational chains
      always_ff @(posedge core_clk_i or negedge rst_n) begin
         if (!rst_n) raw_r[n] <= 1'b0;
         else raw_r[n] <= active && truth_r[n][idx];
      end

      // Input 2 edges are taken from the value the table already uses
      always_ff @(posedge core_clk_i or negedge rst_n) begin
         if (!rst_n) in2_prev_r[n] <= 1'b0;
         else in2_prev_r[n] <= idx[2];
      end

      // Clock source becomes a tick; reserved codes stop the clock
      always_comb begin
         unique case (cl_pkg::clk_src_type'(src))
            cl_pkg::CLK_PERIPH: tick_w[n] = 1'b1;
            cl_pkg::CLK_IN2: tick_w[n] = idx[2] & ~in2_prev_r[n];
            cl_pkg::CLK_FAST:
               tick_w[n] = src_r.fast_osc & ~osc_prev_r[0];
            cl_pkg::CLK_SLOW:
               tick_w[n] = src_r.slow_osc & ~osc_prev_r[1];
            cl_pkg::CLK_DIV_SLOW:
               tick_w[n] = src_r.div_slow_osc & ~osc_prev_r[2];
            default: tick_w[n] = 1'b0;
         endcase
      end

      table_cond u_cond (
         .clk_i(core_clk_i),
         .rst_n_i(rst_n),
         .raw_i(raw_r[n]),
         .tick_i(tick_w[n]),
         .mode_i(ca[cl_pkg::TC_COND_LSB +: 2]),
         .edge_en_i(ca[cl_pkg::TC_EDGE_BIT]),
         .cond_o(cond_w[n])
      );

      // The even table of a pair carries the sequencer result
      assign pre_w[n] = ((n % 2 == 0) && seq_on_w[n/2]) ?
                        seq_q_w[n/2] : cond_w[n];

      // Clocked stages lose their clock in standby without retention
      assign needs_clk_w[n] = active &&
         (ca[cl_pkg::TC_COND_LSB +: 2] != 2'h0 ||
          ca[cl_pkg::TC_EDGE_BIT] || seq_on_w[n/2]);
      assign forced_w[n] = standby_i && !keep_clk && needs_clk_w[n];

      always_ff @(posedge core_clk_i or negedge rst_n) begin
         if (!rst_n) begin
            out_r[n] <= 1'b0;
            out_prev_r[n] <= 1'b0;
         end else begin
            out_r[n] <= forced_w[n] ? 1'b0 : pre_w[n];
            out_prev_r[n] <= out_r[n];
         end
      end

      // Output edges matched against the sense mode
      assign rise = out_r[n] & ~out_prev_r[n];
      assign fall = ~out_r[n] & out_prev_r[n];
      always_comb begin
         unique case (cl_pkg::sense_type'(sense_r[2*n +: 2]))
            cl_pkg::SENSE_OFF: hit_w[n] = 1'b0;
            cl_pkg::SENSE_RISE: hit_w[n] = rise;
            cl_pkg::SENSE_FALL: hit_w[n] = fall;
            cl_pkg::SENSE_BOTH: hit_w[n] = rise | fall;
         endcase
      end

      assign table_output_o[n] = out_r[n];
      // Pin driven while enabled, overriding the port setup
      assign pin_drive_o[n] = active && ca[cl_pkg::TC_DRIVE_BIT];
   end

   // Flags: a new edge in the clearing cycle keeps its flag
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) flags_r <= 4'h0;
      else flags_r <= (flags_r & ~flag_clear) | hit_w;
   end

   // Sense off never sets a flag, so any set flag is an enabled one
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) irq_o <= 1'b0;
      else irq_o <= |((flags_r & ~flag_clear) | hit_w);
   end

   // Clock request in standby with keep set while any active table has a clocked stage, whatever its clock source
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) clock_keep_req_o <= 1'b0;
      else clock_keep_req_o <= keep_clk && standby_i &&
                               (|needs_clk_w);
   end
endmodule : custom_logic_unit

//--- custom_logic_unit_monitor.sv
// Port checker for the custom logic unit.
`timescale 1ns/1ns
module custom_logic_unit_monitor (
   input wire logic core_clk_i, // Clock
   input wire logic arst_n_i, // Reset
   input cl_pkg::reg_req_type bus_i, // Request
   input wire logic [7:0] rd_data_o, // Read data
   input wire logic standby_i, // Standby
   input wire logic [3:0] table_output_o, // Outputs
   input wire logic [3:0] pin_drive_o, // Pin enables
   input wire logic clock_keep_req_o, // Keep request
   input wire logic irq_o // Interrupt
);
   logic [3:0] prev_r;
   logic [3:0] hist_r;
   logic flag_wr;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   // A flag clear can only come from a write to the flag byte
   assign flag_wr = bus_i.wr && (bus_i.addr == cl_pkg::OFF_FLAGS);
   // Recent output changes; a new flag must follow one of them
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_r <= 4'h0;
         hist_r <= 4'h0;
      end else begin
         prev_r <= table_output_o;
         hist_r <= {hist_r[2:0], prev_r != table_output_o};
      end
   end
   sequence main_read;
      bus_i.rd && bus_i.addr == cl_pkg::OFF_MAIN;
   endsequence
   sequence flag_read;
      bus_i.rd && bus_i.addr == cl_pkg::OFF_FLAGS;
   endsequence
   sequence hole_read;
      bus_i.rd && (bus_i.addr inside {5'h03, 5'h04, 5'h06} ||
         bus_i.addr > cl_pkg::OFF_TABLE_LAST);
   endsequence
   rd_idle_a: assert property (rd_data_o != 8'h00 |-> $past(bus_i.rd))
      else $error("read data outside read slot");
   main_mask_a: assert property (main_read |=>
      (rd_data_o & ~cl_pkg::MAIN_READ_MASK) == 8'h00) else $error("main bits");
   flag_upper_a: assert property (flag_read |=>
      rd_data_o[7:4] == 4'h0) else $error("flag upper bits");
   hole_zero_a: assert property (hole_read |=> rd_data_o == 8'h00)
      else $error("unmapped read not zero");
   pin_by_write_a: assert property ($changed(pin_drive_o) |->
      $past(bus_i.wr)) else $error("pin enable moved without write");
   keep_standby_a: assert property (clock_keep_req_o |->
      $past(standby_i)) else $error("keep request outside standby");
   irq_cause_a: assert property ($rose(irq_o) |->
      (|hist_r) || (prev_r != table_output_o)) else $error("irq no edge");
   irq_hold_a: assert property (irq_o && !flag_wr && !$past(flag_wr)
      |=> irq_o) else $error("irq dropped without clear");
   irq_clear_a: assert property ($fell(irq_o) |-> $past(flag_wr) ||
      $past(flag_wr, 2)) else $error("irq fell without clear");
endmodule : custom_logic_unit_monitor

//--- custom_logic_unit_tb_top.sv
// Self-checking bench of the custom logic unit.
`timescale 1ns/1ns
module custom_logic_unit_tb_top;
   logic core_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic standby_i = 1'b0;
   cl_pkg::reg_req_type bus = '0;
   cl_pkg::src_pins_type src = '0;
   logic [7:0] rd_data_o;
   logic [3:0] table_output_o;
   logic [3:0] pin_drive_o;
   logic clock_keep_req_o;
   logic irq_o;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   logic [7:0] regs [0:31];
   logic [3:0] flags = 4'h0;
   logic [3:0] outm = 4'h0;
   always #25 core_clk_i = ~core_clk_i;
   custom_logic_unit uut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
      .bus_i(bus), .rd_data_o(rd_data_o), .src_i(src),
      .standby_i(standby_i), .table_output_o(table_output_o),
      .pin_drive_o(pin_drive_o), .clock_keep_req_o(clock_keep_req_o),
      .irq_o(irq_o));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Read view of the register model; unmapped places read zero
   function automatic logic [7:0] exp_rd(input int a);
      if (a == 0) return regs[0] & cl_pkg::MAIN_READ_MASK;
      if (a == 1 || a == 2) return regs[a] & 8'h0F;
      if (a == 5) return regs[5];
      if (a == 7) return {4'h0, flags};
      if (a < 8 || a > 23) return 8'h00;
      return (a % 4 == 2) ? (regs[a] & 8'h0F) : regs[a];
   endfunction : exp_rd
   task wr(input int a, input logic [7:0] d);
      bus.addr <= 5'(a);
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge core_clk_i);
      bus.wr <= 1'b0;
      if (a == 7) flags = flags & ~d[3:0];
      else if (!(regs[0][0] && (a == 1 || a == 2 || (a >= 8 && a <= 23))))
         regs[a] = d;
      @(posedge core_clk_i);
   endtask : wr
   task rd(input int a);
      bus.addr <= 5'(a);
      bus.rd <= 1'b1;
      @(posedge core_clk_i);
      bus.rd <= 1'b0;
      #1 chk(rd_data_o, exp_rd(a));
      @(posedge core_clk_i);
   endtask : rd
   task end_sim;
      if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   // Hang guard, well above the roughly 670 cycles the run needs
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         end_sim();
      end
   end
   initial begin
      int a;
      int i;
      logic [2:0] v;
      logic [7:0] d;
      logic b;
      foreach (regs[k]) regs[k] = 8'h00;
      d = 8'($urandom(32'h7C6F_213C));
      repeat (2) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      for (a = 0; a < 32; a++) rd(a);
      // Random bytes everywhere, unit kept off so tables stay quiet
      for (a = 0; a < 32; a++) begin
         d = 8'($urandom);
         if (a == 0) d[0] = 1'b0;
         wr(a, d);
         rd(a);
      end
      for (i = 0; i < 5; i++) begin
         wr(1, 8'(i));
         rd(1);
         wr(2, 8'(i));
         rd(2);
      end
      wr(0, 8'h01);
      wr(1, 8'h07);
      rd(1);
      wr(0, 8'h00);
      // Sequencers off, else the even tables would show latch state
      wr(1, 8'h00);
      wr(2, 8'h00);
      // All inputs from pins, never serial or SPI lines
      for (a = 8; a < 24; a += 4) begin
         wr(a, 8'h41);
         wr(a + 1, 8'h55);
         wr(a + 2, 8'h05);
         wr(a + 3, 8'($urandom));
      end
      wr(5, 8'($urandom));
      wr(0, 8'h01);
      chk({4'h0, pin_drive_o}, 8'h0F);
      for (i = 0; i < 16; i++) begin
         v = (i == 0) ? 3'h0 : 3'($urandom);
         src.pin <= {v, v, v, v};
         repeat (10) @(posedge core_clk_i);
         for (a = 0; a < 4; a++) begin
            b = regs[11 + 4 * a][v];
            if (b != outm[a] && regs[5][2 * a + (b ? 0 : 1)]) flags[a] = 1'b1;
            outm[a] = b;
         end
         chk({4'h0, table_output_o}, {4'h0, outm});
         rd(7);
         chk({7'h0, irq_o}, {7'h0, |flags});
         wr(7, 8'($urandom));
      end
      // Standby with and without clock keep on a synchronised table
      wr(0, 8'h00);
      wr(11, 8'hFF);
      wr(8, 8'h11);
      wr(0, 8'h41);
      standby_i <= 1'b1;
      repeat (12) @(posedge core_clk_i);
      chk({7'h0, clock_keep_req_o}, 8'h01);
      chk({7'h0, table_output_o[0]}, 8'h01);
      wr(0, 8'h01);
      repeat (8) @(posedge core_clk_i);
      chk({7'h0, clock_keep_req_o}, 8'h00);
      chk({7'h0, table_output_o[0]}, 8'h00);
      standby_i <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      chk({7'h0, table_output_o[0]}, 8'h01);
      chk({4'h0, pin_drive_o}, 8'h0E);
      // Pair A as D flip-flop: table 1 gates, table 0 gives the data
      wr(0, 8'h00);
      wr(8, 8'h01);
      wr(11, 8'h08);
      wr(15, 8'h0C);
      wr(1, 8'h01);
      wr(0, 8'h01);
      b = 1'b0;
      for (i = 0; i < 8; i++) begin
         v = (i == 0) ? 3'h2 : {1'b0, 2'($urandom)};
         if (v[1]) b = v[0];
         src.pin <= {v, v, v, v};
         repeat (10) @(posedge core_clk_i);
         chk({7'h0, table_output_o[0]}, {7'h0, b});
      end
      // Edge detector turns a level of table 0 into a one-cycle pulse
      wr(0, 8'h00);
      wr(1, 8'h00);
      wr(8, 8'h81);
      src.pin <= 12'h000;
      wr(0, 8'h01);
      repeat (10) @(posedge core_clk_i);
      src.pin <= 12'h003;
      i = 0;
      repeat (12) begin
         @(posedge core_clk_i);
         if (table_output_o[0]) i++;
      end
      chk(8'(i), 8'h01);
      end_sim();
   end
endmodule : custom_logic_unit_tb_top
bind custom_logic_unit custom_logic_unit_monitor mon (.core_clk_i(core_clk_i),
   .arst_n_i(arst_n_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
   .standby_i(standby_i), .table_output_o(table_output_o),
   .pin_drive_o(pin_drive_o), .clock_keep_req_o(clock_keep_req_o),
   .irq_o(irq_o));
